// *** acw_params.svh ***
// Purpose: Offsets, field positions and reset values of the register bank
// Assumes: Included by the bank and its package users
// Notes:   Offsets are word indices; byte address is four times the index
`ifndef ACW_PARAMS_SVH
`define ACW_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define IDX_STATUS      8'h0B
`define IDX_ALARM       8'h0E
`define IDX_RSVD_F      8'h0F
`define IDX_KICK        8'h10
`define IDX_CONFIG      8'h11
`define IDX_RSVD_LO     8'h12
`define IDX_RSVD_HI     8'hFF

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ALARM_MSB       15
`define ALARM_LSB       10
`define CLAMP_SEL_BIT   9
`define KICK_BIT        0
`define LEARN_DONE_BIT  12
`define LEARNED_MSB     7
`define LEARNED_LSB     4
`define CONV_OFF_BIT    0
`define CFG_VOLTAGE_OUTPUT_PIN_EN     0
`define CFG_CURRENT_OUTPUT_PIN_EN     1
`define CFG_ISOLATE     2
`define CFG_FULL_TRACK  3
`define CFG_CLAMP_MSB   7
`define CFG_CLAMP_LSB   4
`define CFG_ACT_MSB     15
`define CFG_ACT_LSB     8

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define ALARM_RST       16'h0000
`define LEARN_THRESH    16'h4000
`define ACT_USER_CODE   2'h1
`define ACT_DISABLE     2'h2
`define CODE_ZERO       16'h0000
`define RDATA_ZERO      32'h0000_0000

`endif

// *** acw_pkg.sv ***
// Purpose: Types shared by the alarm, clamp and watchdog bank
// Assumes: Constants come from acw_params.svh
// Notes:   Learn states are one-hot
`default_nettype none
package acw_pkg;

	// ----------------------------------------------------------------
	// Auto-learn states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		LS_IDLE  = 4'h1,
		LS_TRACK = 4'h2,
		LS_HOLD  = 4'h4,
		LS_DONE  = 4'h8
	} learn_state_t;

	// ----------------------------------------------------------------
	// Output stage switch controls
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       current_output_pin_hiz;
		logic [2:0] voltage_output_pin_stage_closed;
		logic       voltage_output_pin_shunt_closed;
	} switch_ctl_t;

	// ----------------------------------------------------------------
	// Buck-boost controls
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       tracking;
		logic [3:0] clamp_level;
		logic       clamp_26v;
		logic       disabled;
	} bb_ctl_t;

	// ----------------------------------------------------------------
	// Whole bank state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [5:0]   alarm_value;
		logic         clamp_sel;
		logic         voltage_output_pin_en;
		logic         current_output_pin_en;
		logic         isolate;
		logic         full_track;
		logic [3:0]   clamp_set;
		logic [7:0]   actions;
		logic         learn_done;
		logic [3:0]   learned;
		logic         conv_off;
		learn_state_t lstate;
		logic         kick;
		logic         pready;
		logic         pslverr;
		logic [31:0]  prdata;
		logic [15:0]  out_code;
		switch_ctl_t  sw;
		bb_ctl_t      bb;
	} bank_state_t;

	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
		logic [3:0] stable;
	} sync_state_t;

endpackage

`default_nettype wire

// *** acw_pin_sync.sv ***
// Purpose: Three-stage synchroniser for alarm condition pins
// Assumes: Single clock domain core_clk
// Notes:   A change counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module acw_pin_sync
	import acw_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic [3:0] pin_in,
	output logic      [3:0] level
);

	sync_state_t q;
	sync_state_t d;
	logic [3:0]  agreed;

	// ----------------------------------------------------------------
	// Per-bit agreement
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_bit
			assign agreed[gi] = (q.s2[gi] == q.s3[gi]) ?
				q.s3[gi] : q.stable[gi];
		end
	endgenerate

	always_comb begin
		d        = q;
		d.s1     = pin_in;
		d.s2     = q.s1;
		d.s3     = q.s2;
		d.stable = agreed;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign level = q.stable;

endmodule

`default_nettype wire

// *** acw_bank.sv ***
// Purpose: Alarm code, clamp select and watchdog kick registers over APB
// Assumes: Alarm pins are asynchronous; DAC code and load need are local
// Notes:   Zero wait states; every output leaves a flip-flop
//
// Operation
// - A six-bit user alarm value sits in bits 15:10, read/write, reset 0.
// - Bit 9 picks the positive rail clamp: 0 gives 32 V, 1 gives 26 V.
// - Writing 1 to kick bit 0 restarts the watchdog and self-clears.
// - Index 0x0F and 0x12 to 0xFF are reserved and read-only.
// - Voltage on with current off puts the current pin in high-Z.
// - Current on with voltage off opens the three non-shunt switches.
// - Isolate clear keeps the shunt closed while voltage is off.
// - Isolate set opens the shunt so the voltage pin floats when off.
// - Auto-learn picks one clamp level held over the whole current range.
// - Tracking then current enable learns once the code passes 0x4000.
// - Clamp, current enable, then tracking holds clamp until learning.
// - A user-code alarm action drives the stored alarm value out.
// - Learn-done flag in status bit 12 sets on completion, resets to 1.
`timescale 1ns/1ps
`default_nettype none
`include "acw_params.svh"

module acw_bank
	import acw_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  alarm_pins,
	input  wire logic [15:0] dac_code,
	input  wire logic [3:0]  load_need,
	output logic      [15:0] output_code,
	output logic             watchdog_kick,
	output logic             positive_rail_clamp_select,
	output logic             learn_done_flag,
	output switch_ctl_t      switches,
	output bb_ctl_t          buck_boost
);

	bank_state_t q;
	bank_state_t d;
	logic [3:0]  alarm_lvl;
	logic [3:0]  hit_code;
	logic [3:0]  hit_off;
	logic [7:0]  idx;
	logic        setup;
	logic        commit;
	logic        aligned;
	logic        rsvd;
	logic        mapped;
	logic        wr_alarm;
	logic        wr_kick;
	logic        wr_cfg;
	logic        wr_stat;
	logic        over_thr;
	logic        learn_hit;
	logic        use_code;

	// ----------------------------------------------------------------
	// Alarm pin synchroniser
	// ----------------------------------------------------------------
	acw_pin_sync u_sync (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pin_in   (alarm_pins),
		.level    (alarm_lvl)
	);

	// ----------------------------------------------------------------
	// Per-condition alarm action decode
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_act
			assign hit_code[gi] = alarm_lvl[gi] &&
				(q.actions[2*gi+1:2*gi] == `ACT_USER_CODE);
			assign hit_off[gi] = alarm_lvl[gi] &&
				(q.actions[2*gi+1:2*gi] == `ACT_DISABLE);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign idx      = paddr[9:2];
	assign aligned  = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
	assign rsvd     = (idx == `IDX_RSVD_F) || (idx >= `IDX_RSVD_LO);
	assign mapped   = aligned && (rsvd || idx == `IDX_STATUS ||
		idx == `IDX_ALARM || idx == `IDX_KICK || idx == `IDX_CONFIG);
	assign setup    = psel && !penable;
	assign commit   = psel && penable && q.pready && pwrite && mapped;
	// Reserved indices take no write; bus still completes cleanly
	assign wr_alarm = commit && (idx == `IDX_ALARM);
	assign wr_kick  = commit && (idx == `IDX_KICK);
	assign wr_cfg   = commit && (idx == `IDX_CONFIG);
	assign wr_stat  = commit && (idx == `IDX_STATUS);
	assign over_thr = dac_code > `LEARN_THRESH;
	assign use_code = |hit_code;
	assign learn_hit = over_thr && ((q.lstate == LS_TRACK) ||
		(q.lstate == LS_HOLD && q.full_track));

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;

		// Bus answer prepared in the setup cycle
		d.pready  = setup;
		d.pslverr = setup && !mapped;
		d.prdata  = `RDATA_ZERO;
		if (setup && mapped && !rsvd) begin
			unique case (idx)
				`IDX_ALARM: begin
					d.prdata[`ALARM_MSB:`ALARM_LSB] = q.alarm_value;
					d.prdata[`CLAMP_SEL_BIT] = q.clamp_sel;
				end
				`IDX_STATUS: begin
					d.prdata[`LEARN_DONE_BIT] = q.learn_done;
					d.prdata[`LEARNED_MSB:`LEARNED_LSB] = q.learned;
					d.prdata[`CONV_OFF_BIT] = q.conv_off;
				end
				`IDX_CONFIG: begin
					d.prdata[`CFG_VOLTAGE_OUTPUT_PIN_EN] = q.voltage_output_pin_en;
					d.prdata[`CFG_CURRENT_OUTPUT_PIN_EN] = q.current_output_pin_en;
					d.prdata[`CFG_ISOLATE] = q.isolate;
					d.prdata[`CFG_FULL_TRACK] = q.full_track;
					d.prdata[`CFG_CLAMP_MSB:`CFG_CLAMP_LSB] = q.clamp_set;
					d.prdata[`CFG_ACT_MSB:`CFG_ACT_LSB] = q.actions;
				end
				// Kick bit is write-only; reads as zero
				default: d.prdata = `RDATA_ZERO;
			endcase
		end

		// Register writes; alarm bit 8 and bits 7:0 are not kept
		if (wr_alarm) begin
			d.alarm_value = pwdata[`ALARM_MSB:`ALARM_LSB];
			d.clamp_sel   = pwdata[`CLAMP_SEL_BIT];
		end
		if (wr_cfg) begin
			d.voltage_output_pin_en    = pwdata[`CFG_VOLTAGE_OUTPUT_PIN_EN];
			d.current_output_pin_en    = pwdata[`CFG_CURRENT_OUTPUT_PIN_EN];
			d.isolate    = pwdata[`CFG_ISOLATE];
			d.full_track = pwdata[`CFG_FULL_TRACK];
			d.clamp_set  = pwdata[`CFG_CLAMP_MSB:`CFG_CLAMP_LSB];
			d.actions    = pwdata[`CFG_ACT_MSB:`CFG_ACT_LSB];
		end

		// Kick lasts one cycle then clears itself
		d.kick = wr_kick && pwdata[`KICK_BIT];

		// Auto-learn sequencing
		unique case (q.lstate)
			LS_IDLE: begin
				if (q.current_output_pin_en && q.full_track) begin
					d.lstate = LS_TRACK;
				end else if (q.current_output_pin_en) begin
					d.lstate = LS_HOLD;
				end
			end
			LS_TRACK: begin
				if (!q.current_output_pin_en) begin
					d.lstate = LS_IDLE;
				end else if (learn_hit) begin
					d.lstate = LS_DONE;
				end
			end
			LS_HOLD: begin
				if (!q.current_output_pin_en) begin
					d.lstate = LS_IDLE;
				end else if (learn_hit) begin
					d.lstate = LS_DONE;
				end
			end
			LS_DONE: begin
				if (!q.current_output_pin_en) begin
					d.lstate = LS_IDLE;
				end
			end
			default: d.lstate = LS_IDLE;
		endcase
		if (learn_hit && q.current_output_pin_en) begin
			d.learned = load_need;
		end

		// Hardware set beats a software clear in the same cycle
		if (wr_stat) begin
			d.learn_done = pwdata[`LEARN_DONE_BIT];
		end
		if (learn_hit && q.current_output_pin_en) begin
			d.learn_done = 1'b1;
		end

		// Disable action latches until reset
		if (|hit_off) begin
			d.conv_off = 1'b1;
		end

		// Output code selection
		if (q.conv_off) begin
			d.out_code = `CODE_ZERO;
		end else if (use_code) begin
			d.out_code = {q.alarm_value, 10'h000};
		end else begin
			d.out_code = dac_code;
		end

		// Pin isolation switches
		d.sw.current_output_pin_hiz = !q.current_output_pin_en || q.conv_off;
		d.sw.voltage_output_pin_stage_closed = (q.voltage_output_pin_en && !q.conv_off) ?
			3'h7 : 3'h0;
		if (q.voltage_output_pin_en && !q.conv_off) begin
			d.sw.voltage_output_pin_shunt_closed = 1'b1;
		end else if (q.isolate) begin
			d.sw.voltage_output_pin_shunt_closed = 1'b0;
		end else begin
			d.sw.voltage_output_pin_shunt_closed = 1'b1;
		end

		// Buck-boost level: learned value stays fixed once done
		d.bb.clamp_26v = q.clamp_sel;
		d.bb.disabled  = q.conv_off;
		unique case (q.lstate)
			LS_DONE: begin
				d.bb.tracking    = 1'b0;
				d.bb.clamp_level = q.learned;
			end
			LS_HOLD: begin
				d.bb.tracking    = 1'b0;
				d.bb.clamp_level = q.clamp_set;
			end
			LS_TRACK: begin
				d.bb.tracking    = 1'b1;
				d.bb.clamp_level = q.clamp_set;
			end
			default: begin
				d.bb.tracking    = q.full_track;
				d.bb.clamp_level = q.clamp_set;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			q            <= '0;
			q.lstate     <= LS_IDLE;
			q.learn_done <= 1'b1;
			q.sw.current_output_pin_hiz <= 1'b1;
			q.sw.voltage_output_pin_shunt_closed <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign prdata      = q.prdata;
	assign pready      = q.pready;
	assign pslverr     = q.pslverr;
	assign output_code = q.out_code;
	assign watchdog_kick = q.kick;
	assign positive_rail_clamp_select = q.clamp_sel;
	assign learn_done_flag = q.learn_done;
	assign switches    = q.sw;
	assign buck_boost  = q.bb;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_alarm_write: assert property (@(posedge core_clk) disable iff (sys_rst)
		wr_alarm |=> q.alarm_value == $past(pwdata[15:10]))
		else $error("alarm value not stored");

	a_clamp_out: assert property (@(posedge core_clk) disable iff (sys_rst)
		wr_alarm |=> ##1 buck_boost.clamp_26v == $past(pwdata[9], 2))
		else $error("clamp select not forwarded");

	a_kick_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
		(wr_kick && pwdata[0]) |=> watchdog_kick ##1 !watchdog_kick)
		else $error("kick not a single pulse");

	a_rsvd_read: assert property (@(posedge core_clk) disable iff (sys_rst)
		(setup && aligned && rsvd) |=> pready && !pslverr
		&& prdata == 32'h0000_0000)
		else $error("reserved read not zero");

	a_current_output_pin_hiz: assert property (@(posedge core_clk) disable iff (sys_rst)
		(q.voltage_output_pin_en && !q.current_output_pin_en) |=> switches.current_output_pin_hiz)
		else $error("current pin driven while off");

	a_stage_open: assert property (@(posedge core_clk) disable iff (sys_rst)
		(q.current_output_pin_en && !q.voltage_output_pin_en) |=> switches.voltage_output_pin_stage_closed == 3'h0)
		else $error("voltage stage switches closed");

	a_shunt_closed: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		(!q.voltage_output_pin_en && !q.isolate) |=> switches.voltage_output_pin_shunt_closed)
		else $error("shunt open without isolate");

	a_shunt_open: assert property (@(posedge core_clk) disable iff (sys_rst)
		(!q.voltage_output_pin_en && q.isolate) |=> !switches.voltage_output_pin_shunt_closed)
		else $error("shunt closed with isolate");

	a_clamp_fixed: assert property (@(posedge core_clk) disable iff (sys_rst)
		(q.lstate == LS_DONE && $past(q.lstate) == LS_DONE)
		|-> $stable(q.learned))
		else $error("learned clamp moved");

	a_learn_track: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		(q.lstate == LS_TRACK && q.current_output_pin_en && dac_code > `LEARN_THRESH)
		|=> q.lstate == LS_DONE ##1 buck_boost.clamp_level == q.learned)
		else $error("tracking learn missed");

	a_learn_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
		(q.lstate == LS_HOLD && !q.full_track && q.current_output_pin_en)
		|=> !buck_boost.tracking && q.lstate != LS_DONE)
		else $error("clamp not held");

	a_user_code: assert property (@(posedge core_clk) disable iff (sys_rst)
		(use_code && !q.conv_off) |=>
		output_code[15:10] == $past(q.alarm_value))
		else $error("user alarm value not driven");

	a_learn_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
		(learn_hit && q.current_output_pin_en) |=> learn_done_flag)
		else $error("learn done flag not set");

endmodule

`default_nettype wire

// *** test_alarm_clamp_watchdog_regs.sv ***
// Purpose: Self-checking bench for the alarm, clamp and watchdog bank
// Assumes: APB slave answers after one access cycle; bench is the master
// Notes:   Reset values and register table rows first, then kick, switch, learn, alarm and reset cases
`timescale 1ns/1ps
`default_nettype none
`include "acw_params.svh"

module test_alarm_clamp_watchdog_regs
	import acw_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        w;
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] exp;
		logic        err;
		logic        clamp;
	} row_t;

	logic        core_clk = 1'b0;
	logic        sys_rst  = 1'b1;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [11:0] paddr    = 12'h000;
	logic [31:0] pwdata   = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  alarm_pins = 4'h0;
	logic [15:0] dac_code   = 16'h0000;
	logic [3:0]  load_need  = 4'h0;
	logic [15:0] output_code;
	logic        watchdog_kick;
	logic        positive_rail_clamp_select;
	logic        learn_done_flag;
	switch_ctl_t switches;
	bb_ctl_t     buck_boost;
	int          mismatches  = 0;
	int          tests_run   = 0;
	int          cycles      = 0;
	int          kick_pulses = 0;
	logic [31:0] rd;
	logic        er;

	// Rows: write flag, byte address, data, expected read, error, clamp
	row_t rows [0:10] = '{
		'{1'b1, 12'h038, 32'h0000_FE00, 32'h0, 1'b0, 1'b1},
		'{1'b0, 12'h038, 32'h0, 32'h0000_FE00, 1'b0, 1'b1},
		'{1'b1, 12'h039, 32'h0, 32'h0, 1'b1, 1'b1},
		'{1'b0, 12'h038, 32'h0, 32'h0000_FE00, 1'b0, 1'b1},
		'{1'b0, 12'h03C, 32'h0, 32'h0, 1'b0, 1'b1},
		'{1'b0, 12'h048, 32'h0, 32'h0, 1'b0, 1'b1},
		'{1'b0, 12'h3FC, 32'h0, 32'h0, 1'b0, 1'b1},
		'{1'b0, 12'h040, 32'h0, 32'h0, 1'b0, 1'b1},
		'{1'b0, 12'h000, 32'h0, 32'h0, 1'b1, 1'b1},
		'{1'b1, 12'h038, 32'h0000_0400, 32'h0, 1'b0, 1'b0},
		'{1'b0, 12'h438, 32'h0, 32'h0, 1'b1, 1'b0}
	};

	acw_bank dut (
		.core_clk                   (core_clk),
		.sys_rst                    (sys_rst),
		.psel                       (psel),
		.penable                    (penable),
		.pwrite                     (pwrite),
		.paddr                      (paddr),
		.pwdata                     (pwdata),
		.prdata                     (prdata),
		.pready                     (pready),
		.pslverr                    (pslverr),
		.alarm_pins                 (alarm_pins),
		.dac_code                   (dac_code),
		.load_need                  (load_need),
		.output_code                (output_code),
		.watchdog_kick              (watchdog_kick),
		.positive_rail_clamp_select (positive_rail_clamp_select),
		.learn_done_flag            (learn_done_flag),
		.switches                   (switches),
		.buck_boost                 (buck_boost)
	);

	// ----------------------------------------------------------------
	// Clock, timeout and pulse counter
	// ----------------------------------------------------------------
	always #12.5 core_clk = ~core_clk;

	// Ceiling well above the few hundred cycles the cases need
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (watchdog_kick === 1'b1)
			kick_pulses <= kick_pulses + 1;
		if (cycles == 4000) begin
			mismatches++;
			give_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t data got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_flag(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t flag got %b expected %b", $time, got, exp);
		end
	endtask

	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic [11:0] a, input logic w,
			input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			check_flag(1'b0, 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_learn(input logic exp);
		for (int i = 0; i < 12 && learn_done_flag !== exp; i++)
			@(posedge core_clk);
		check_flag(learn_done_flag, exp);
	endtask

	task automatic wait_code(input logic [15:0] exp);
		for (int i = 0; i < 12 && output_code !== exp; i++)
			@(posedge core_clk);
		check_data({16'h0000, output_code}, {16'h0000, exp});
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		check_flag(learn_done_flag, 1'b1);
		check_data({27'h0, switches}, 32'h0000_0011);
		apb(12'h038, 1'b0, 32'h0);
		check_data(rd, 32'h0000_0000);
		$display("test reset_values done");

		foreach (rows[i]) begin
			apb(rows[i].a, rows[i].w, rows[i].d);
			check_flag(er, rows[i].err);
			if (!rows[i].w)
				check_data(rd, rows[i].exp);
			@(posedge core_clk);
			check_flag(positive_rail_clamp_select, rows[i].clamp);
		end
		$display("test register_rows done");

		// Two kicks, each must give a single one-cycle pulse
		apb(12'h040, 1'b1, 32'h0000_0001);
		apb(12'h040, 1'b1, 32'h0000_0001);
		repeat (3) @(posedge core_clk);
		check_data(kick_pulses, 32'd2);
		apb(12'h040, 1'b0, 32'h0);
		check_data(rd, 32'h0000_0000);
		$display("test watchdog_kick done");

		// Config: voltage_output_pin on; current_output_pin on; current_output_pin on with isolate
		apb(12'h044, 1'b1, 32'h0000_0001);
		repeat (2) @(posedge core_clk);
		check_data({27'h0, switches}, 32'h0000_001F);
		apb(12'h044, 1'b1, 32'h0000_0002);
		repeat (2) @(posedge core_clk);
		check_data({27'h0, switches}, 32'h0000_0001);
		apb(12'h044, 1'b1, 32'h0000_0006);
		repeat (2) @(posedge core_clk);
		check_data({27'h0, switches}, 32'h0000_0000);
		$display("test switch_states done");

		// Tracking entry; 0x4000 itself must not trigger learning
		apb(12'h044, 1'b1, 32'h0000_0000);
		apb(12'h02C, 1'b1, 32'h0000_0000);
		dac_code  <= 16'h4000;
		load_need <= 4'h9;
		apb(12'h044, 1'b1, 32'h0000_000A);
		repeat (6) @(posedge core_clk);
		check_flag(learn_done_flag, 1'b0);
		check_flag(buck_boost.tracking, 1'b1);
		dac_code <= 16'h4001;
		wait_learn(1'b1);
		repeat (2) @(posedge core_clk);
		check_data(buck_boost.clamp_level, 32'h9);
		load_need <= 4'h3;
		dac_code  <= 16'hFFFF;
		repeat (4) @(posedge core_clk);
		check_data(buck_boost.clamp_level, 32'h9);
		apb(12'h02C, 1'b0, 32'h0);
		check_data(rd, 32'h0000_1090);
		$display("test learn_tracking done");

		// Clamp-mode entry, then tracking selected
		apb(12'h044, 1'b1, 32'h0000_0000);
		apb(12'h02C, 1'b1, 32'h0000_0000);
		load_need <= 4'h5;
		dac_code  <= 16'h5000;
		apb(12'h044, 1'b1, 32'h0000_00C2);
		repeat (4) @(posedge core_clk);
		check_flag(learn_done_flag, 1'b0);
		check_data(buck_boost.clamp_level, 32'hC);
		check_flag(buck_boost.tracking, 1'b0);
		apb(12'h044, 1'b1, 32'h0000_00CA);
		wait_learn(1'b1);
		repeat (2) @(posedge core_clk);
		check_data(buck_boost.clamp_level, 32'h5);
		$display("test learn_clamp done");

		// User-code action on the first alarm pin
		apb(12'h038, 1'b1, 32'h0000_A800);
		apb(12'h044, 1'b1, 32'h0000_0101);
		dac_code <= 16'h1234;
		wait_code(16'h1234);
		alarm_pins <= 4'h1;
		wait_code(16'hA800);
		alarm_pins <= 4'h0;
		wait_code(16'h1234);
		$display("test user_code_alarm done");

		// Disable action on the second pin latches until reset
		apb(12'h044, 1'b1, 32'h0000_0803);
		alarm_pins <= 4'h2;
		wait_code(16'h0000);
		alarm_pins <= 4'h0;
		repeat (6) @(posedge core_clk);
		check_data({16'h0000, output_code}, 32'h0000_0000);
		check_data({27'h0, switches}, 32'h0000_0011);
		check_flag(buck_boost.disabled, 1'b1);
		apb(12'h02C, 1'b0, 32'h0);
		check_data(rd, 32'h0000_1051);
		$display("test disable_alarm done");

		// Second reset in mid-run, with the 26 V clamp selected first
		apb(12'h038, 1'b1, 32'h0000_FE00);
		repeat (2) @(posedge core_clk);
		check_flag(buck_boost.clamp_26v, 1'b1);
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		check_flag(positive_rail_clamp_select, 1'b0);
		check_flag(buck_boost.disabled, 1'b0);
		apb(12'h038, 1'b0, 32'h0);
		check_data(rd, 32'h0000_0000);
		$display("test mid_reset done");
		give_verdict();
	end
endmodule
`default_nettype wire
